// ### src/tccc_channel.sv
// Purpose: One timer channel counter with clock, edge and clear selection.
// Assumes: Divider taps are free-running levels on pclk.
// Notes: Counter is loaded by software only through cnt_wr.
module tccc_channel
    import tccc_pkg::*;
(
    input wire logic pclk, // Peripheral clock
    input wire logic presetn, // Async reset, active low
    input wire logic [TCCC_DIV_W-1:0] div_q, // Shared prescaler divider
    input wire tccc_ctrl_t ctrl, // Count control fields
    input wire tccc_general_t gen, // General registers
    input wire logic run, // Channel started
    input wire logic cnt_wr, // Software counter write
    input wire logic [TCCC_CNT_W-1:0] cnt_wdata, // Counter write data
    output logic [TCCC_CNT_W-1:0] count // Counter value
);
    logic tap_now;
    logic tap_reg;
    logic tick;
    logic clr_hit;

    always_comb begin
        case (ctrl.prescale[1:0])
            2'h1: tap_now = div_q[TCCC_TAP4];
            2'h2: tap_now = div_q[TCCC_TAP16];
            2'h3: tap_now = div_q[TCCC_TAP64];
            default: tap_now = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_reg <= 1'b0;
        end else begin
            tap_reg <= tap_now;
        end
    end

    // Undivided clock counts every cycle; edge choice has no meaning there
    always_comb begin
        if (ctrl.prescale[1:0] == 2'h0) begin
            tick = 1'b1;
        end else if (ctrl.edge_sel[1]) begin
            tick = tap_now ^ tap_reg;
        end else if (ctrl.edge_sel[0]) begin
            tick = tap_reg & ~tap_now;
        end else begin
            tick = tap_now & ~tap_reg;
        end
    end

    always_comb begin
        case (ctrl.clear_sel)
            TCCC_CLR_A: clr_hit = (count == gen.a);
            TCCC_CLR_B: clr_hit = (count == gen.b);
            TCCC_CLR_C: clr_hit = (count == gen.c);
            TCCC_CLR_D: clr_hit = (count == gen.d);
            default: clr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (cnt_wr) begin
            count <= cnt_wdata;
        end else if (run && tick) begin
            if (clr_hit) begin
                count <= '0;
            end else begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule : tccc_channel

// ### src/tccc_pkg.sv
// Purpose: Shared constants and types for the timer count control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses; the channel stride is 0x20.
package tccc_pkg;
    localparam int TCCC_CHANNELS = 4;
    localparam int TCCC_CNT_W = 16;
    localparam int TCCC_ADDR_W = 8;
    // Per-channel register offsets within the channel window, then shared register addresses
    localparam logic [7:0] TCCC_CH_STRIDE = 8'h20;
    localparam logic [4:0] TCCC_OFS_CTRL = 5'h00;
    localparam logic [4:0] TCCC_OFS_CNT = 5'h04;
    localparam logic [4:0] TCCC_OFS_GRA = 5'h08;
    localparam logic [4:0] TCCC_OFS_GRB = 5'h0c;
    localparam logic [4:0] TCCC_OFS_GRC = 5'h10;
    localparam logic [4:0] TCCC_OFS_GRD = 5'h14;
    localparam logic [4:0] TCCC_OFS_MODE = 5'h18;
    localparam logic [4:0] TCCC_OFS_PIN_IO = 5'h1c;
    localparam logic [7:0] TCCC_OFS_IRQ_EN = 8'h80;
    localparam logic [7:0] TCCC_OFS_STATUS = 8'h84;
    localparam logic [7:0] TCCC_OFS_START = 8'h88;
    // Control field layout
    localparam int TCCC_CLR_LSB = 5;
    localparam int TCCC_EDGE_LSB = 3;
    localparam int TCCC_PSC_LSB = 0;
    localparam logic [7:0] TCCC_CTRL_MASK = 8'hff;
    localparam logic [15:0] TCCC_CTRL_RESET = 16'h0000;
    // Clear selector codes
    localparam logic [2:0] TCCC_CLR_A = 3'h1;
    localparam logic [2:0] TCCC_CLR_B = 3'h2;
    localparam logic [2:0] TCCC_CLR_C = 3'h5;
    localparam logic [2:0] TCCC_CLR_D = 3'h6;
    // Prescaler tap bit positions in the free-running divider
    localparam int TCCC_DIV_W = 6;
    localparam int TCCC_TAP4 = 1;
    localparam int TCCC_TAP16 = 3;
    localparam int TCCC_TAP64 = 5;

    typedef struct packed {
        logic [2:0] clear_sel;
        logic [1:0] edge_sel;
        logic [2:0] prescale;
    } tccc_ctrl_t;

    typedef struct packed {
        logic [TCCC_CNT_W-1:0] a;
        logic [TCCC_CNT_W-1:0] b;
        logic [TCCC_CNT_W-1:0] c;
        logic [TCCC_CNT_W-1:0] d;
    } tccc_general_t;
endpackage : tccc_pkg

// ### src/tccc_top.sv
// Purpose: Four-channel 16-bit timer count control with APB registers.
// Assumes: Software changes count control only while a channel is stopped.
// Notes: Mode, pin and interrupt registers are storage only here.
//
// Decided for this implementation: the address map and the APB slave port.
module tccc_top
    import tccc_pkg::*;
(
    input wire logic pclk, // Peripheral clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [TCCC_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic [TCCC_CHANNELS-1:0] running // Channel start state
);
    logic [TCCC_DIV_W-1:0] div_reg;
    tccc_ctrl_t ctrl_reg [TCCC_CHANNELS];
    tccc_general_t gen_reg [TCCC_CHANNELS];
    logic [15:0] mode_reg [TCCC_CHANNELS];
    logic [15:0] pin_io_reg [TCCC_CHANNELS];
    logic [TCCC_CNT_W-1:0] count [TCCC_CHANNELS];
    logic [7:0] irq_enable_reg;
    logic [7:0] channel_status_reg;
    logic [TCCC_CHANNELS-1:0] start_reg;
    logic [TCCC_CHANNELS-1:0] cnt_wr;
    logic access;
    logic wr;
    logic in_ch;
    logic [1:0] ch_idx;
    logic [4:0] ch_ofs;
    logic mapped;
    logic [31:0] rd_next;
    logic [15:0] wdat;

    assign access = psel & penable & ~pready;
    assign wr = access & pwrite;
    assign in_ch = (paddr < TCCC_OFS_IRQ_EN);
    assign ch_idx = paddr[6:5];
    assign ch_ofs = paddr[4:0];
    // Low two byte lanes hold the 16-bit registers; they take a write only when both lane strobes are set
    always_comb begin
        wdat = 16'h0000;
        wdat[7:0] = pwdata[7:0];
        wdat[15:8] = pwdata[15:8];
    end

    // Free-running divider shared by all channels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 6'h01;
        end
    end

    // Per-channel register storage
    generate
        for (genvar i = 0; i < TCCC_CHANNELS; i++) begin : g_ch
            logic sel;
            assign sel = wr && in_ch && (ch_idx == 2'(i));
            assign cnt_wr[i] = sel && (ch_ofs == TCCC_OFS_CNT)
                && (pstrb[1:0] == 2'h3);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl_reg[i] <= tccc_ctrl_t'(TCCC_CTRL_RESET[7:0]);
                end else if (sel && ch_ofs == TCCC_OFS_CTRL && pstrb[0]) begin
                    ctrl_reg[i] <= tccc_ctrl_t'(wdat[7:0]);
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gen_reg[i] <= '1;
                    mode_reg[i] <= 16'h0000;
                    pin_io_reg[i] <= 16'h0000;
                end else if (sel && pstrb[1:0] == 2'h3) begin
                    if (ch_ofs == TCCC_OFS_GRA) begin
                        gen_reg[i].a <= wdat;
                    end else if (ch_ofs == TCCC_OFS_GRB) begin
                        gen_reg[i].b <= wdat;
                    end else if (ch_ofs == TCCC_OFS_GRC) begin
                        gen_reg[i].c <= wdat;
                    end else if (ch_ofs == TCCC_OFS_GRD) begin
                        gen_reg[i].d <= wdat;
                    end else if (ch_ofs == TCCC_OFS_MODE) begin
                        mode_reg[i] <= wdat;
                    end else if (ch_ofs == TCCC_OFS_PIN_IO) begin
                        pin_io_reg[i] <= wdat;
                    end
                end
            end

            tccc_channel u_channel (
                .pclk(pclk),
                .presetn(presetn),
                .div_q(div_reg),
                .ctrl(ctrl_reg[i]),
                .gen(gen_reg[i]),
                .run(start_reg[i]),
                .cnt_wr(cnt_wr[i]),
                .cnt_wdata(wdat),
                .count(count[i])
            );
        end
    endgenerate

    // Shared registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_reg <= 8'h00;
            channel_status_reg <= 8'h00;
            start_reg <= '0;
        end else if (wr && pstrb[0]) begin
            if (paddr == TCCC_OFS_IRQ_EN) begin
                irq_enable_reg <= pwdata[7:0];
            end else if (paddr == TCCC_OFS_STATUS) begin
                channel_status_reg <= channel_status_reg & pwdata[7:0];
            end else if (paddr == TCCC_OFS_START) begin
                start_reg <= pwdata[TCCC_CHANNELS-1:0];
            end
        end
    end

    // Read decode
    always_comb begin
        rd_next = 32'h0000_0000;
        mapped = 1'b1;
        if (in_ch) begin
            if (ch_ofs == TCCC_OFS_CTRL) begin
                rd_next[7:0] = ctrl_reg[ch_idx];
            end else if (ch_ofs == TCCC_OFS_CNT) begin
                rd_next[15:0] = count[ch_idx];
            end else if (ch_ofs == TCCC_OFS_GRA) begin
                rd_next[15:0] = gen_reg[ch_idx].a;
            end else if (ch_ofs == TCCC_OFS_GRB) begin
                rd_next[15:0] = gen_reg[ch_idx].b;
            end else if (ch_ofs == TCCC_OFS_GRC) begin
                rd_next[15:0] = gen_reg[ch_idx].c;
            end else if (ch_ofs == TCCC_OFS_GRD) begin
                rd_next[15:0] = gen_reg[ch_idx].d;
            end else if (ch_ofs == TCCC_OFS_MODE) begin
                rd_next[15:0] = mode_reg[ch_idx];
            end else if (ch_ofs == TCCC_OFS_PIN_IO) begin
                rd_next[15:0] = pin_io_reg[ch_idx];
            end else begin
                mapped = 1'b0;
            end
        end else if (paddr == TCCC_OFS_IRQ_EN) begin
            rd_next[7:0] = irq_enable_reg;
        end else if (paddr == TCCC_OFS_STATUS) begin
            rd_next[7:0] = channel_status_reg;
        end else if (paddr == TCCC_OFS_START) begin
            rd_next[TCCC_CHANNELS-1:0] = start_reg;
        end else begin
            mapped = 1'b0;
        end
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access & ~mapped;
            if (access && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running <= '0;
        end else begin
            running <= start_reg;
        end
    end
endmodule : tccc_top

// ### verification/tb.sv
// Purpose: Self-checking bench for the timer count control block.
// Assumes: Counting runs only between the start and stop writes.
// Notes: Divider phase is unknown, so counts are judged in a window.
module tb
    import tccc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0] pstrb, running;
    logic [15:0] q;
    int miscompares, num_checks, d, per, x, ex;
    tccc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .running(running));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic finish_test;
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Look mid-cycle: the value seen is what the next rising edge samples
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        {psel, penable} <= 2'b00;
        if (n >= 20) begin
            miscompares++;
            finish_test();
        end else begin
            check("pslverr", {31'h0, er}, {31'h0, a > 8'h88});
        end
    endtask : apb
    task automatic run(input int ch, input logic [7:0] c,
                       input logic [15:0] c0, input int n);
        apb(1, 8'(ch * 32), {24'h0, c});
        apb(1, 8'(ch * 32) + 8'h04, {16'h0, c0});
        apb(1, TCCC_OFS_START, 32'h1 << ch);
        repeat (n) @(posedge pclk);
        apb(1, TCCC_OFS_START, 32'h0);
        apb(0, 8'(ch * 32) + 8'h04, 32'h0);
        q = rd[15:0];
    endtask : run
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        seed = 32'h7ab7c149;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int ch = 0; ch < 4; ch++) begin
            apb(0, 8'(ch * 32), 32'h0);
            check("ctrl reset", rd, 32'h0);
        end
        // Low byte kept legal: no prohibited clear or prescale code
        apb(1, 8'h20, 32'hffffffd2);
        apb(0, 8'h20, 32'h0);
        check("ctrl width", rd, 32'h000000d2);
        for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            d = 200 + int'(seed[7:0]);
            per = (k % 4 == 0) ? 1 : 4 ** (k % 4);
            if (k >= 8 && per > 1) per = per / 2;
            run(k % 4, {3'b000, 2'(k / 4), 1'b0, 2'(k % 4)}, 16'h0, d);
            ex = (d + 3) / per;
            check("count", {31'h0, int'(q) + 2 >= ex && int'(q) <= ex + 2},
                  32'h1);
        end
        for (int cd = 0; cd < 8; cd++) begin
            if (cd == 3 || cd == 7) continue;
            seed = lfsr(seed);
            x = 8 + int'(seed[4:0]);
            for (int g = 0; g < 4; g++) begin
                apb(1, 8'((cd % 4) * 32 + 8 + g * 4),
                    (cd == ((g < 2) ? g + 1 : g + 3)) ? x : 32'hffff);
            end
            run(cd % 4, {3'(cd), 5'h0}, 16'h0, 200);
            // Run spans the start and stop accesses: 200 waits give 204 ticks
            ex = (cd % 4 == 0) ? 204 : 204 % (x + 1);
            check("clear", {16'h0, q}, ex);
        end
        run(2, 8'h00, 16'hfff0, 40);
        check("wrap", {16'h0, q}, 32'h0000001c);
        apb(0, 8'hc0, 32'h0);
        apb(1, 8'h8c, 32'h1);
        finish_test();
    end
endmodule : tb

// ### verification/tccc_asserts.sv
// Purpose: Port-level checks for the timer count control block.
// Assumes: Two-cycle APB access phase, one-cycle ready pulse.
// Notes: Bound onto tccc_top at the foot of this file.
module tccc_asserts
    import tccc_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Write
    input wire logic [TCCC_ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [3:0] pstrb, // Strobes
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [TCCC_CHANNELS-1:0] running // Start state
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_taken;
        psel && penable && !pready;
    endsequence
    sequence s_read(logic [4:0] ofs);
        psel && penable && pready && !pwrite && paddr < 8'h80
            && paddr[4:0] == ofs;
    endsequence
    sequence s_start_wr;
        psel && penable && pready && pwrite && paddr == TCCC_OFS_START
            && pstrb == 4'hf;
    endsequence
    AST_READY_NEXT: assert property (s_taken |=> pready)
        else $error("no ready after access");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_UNMAPPED: assert property (
        s_taken ##0 paddr > 8'h88 |=> pslverr)
        else $error("unmapped access not refused");
    AST_CTRL_UPPER: assert property (
        s_read(TCCC_OFS_CTRL) |-> prdata[31:8] == 24'h0)
        else $error("control upper bits not zero");
    AST_CNT_WIDTH: assert property (
        s_read(TCCC_OFS_CNT) |-> prdata[31:16] == 16'h0)
        else $error("counter wider than 16 bits");
    AST_START_COPY: assert property (
        s_start_wr |=> running == $past(pwdata[3:0]))
        else $error("start state not updated");
    AST_RESET_QUIET: assert property (
        !$past(presetn) |-> !pready && running == 4'h0)
        else $error("outputs active after reset");
endmodule : tccc_asserts

bind tccc_top tccc_asserts u_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .running(running)
);
